// *** hw/ghs_pkg.sv ***
// Package of constants and types for the instrument-side bus interface.
package ghs_pkg;

    // -------------------------------------------------------------------
    // Bus command codes, taken while the attention line is asserted.
    // -------------------------------------------------------------------
    localparam logic [2:0] GHS_CMD_GROUP_MASK = 3'h3;
    localparam logic [1:0] GHS_GROUP_LISTEN   = 2'h1;
    localparam logic [1:0] GHS_GROUP_TALK     = 2'h2;
    localparam logic [1:0] GHS_GROUP_UNIV     = 2'h0;
    localparam logic [4:0] GHS_ADDR_UNCMD     = 5'h1F;
    localparam logic [6:0] GHS_CMD_DCL        = 7'h14;
    localparam logic [6:0] GHS_CMD_GTL        = 7'h01;
    localparam logic [6:0] GHS_CMD_LLO        = 7'h11;
    localparam logic [6:0] GHS_CMD_SDC        = 7'h04;

    // Default primary address of the instrument.
    localparam logic [4:0] GHS_DEF_ADDR       = 5'h02;

    // -------------------------------------------------------------------
    // Handshake state machines.
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        GHS_SRC_IDLE,
        GHS_SRC_SETUP,
        GHS_SRC_VALID,
        GHS_SRC_DONE
    } ghs_src_type;

    typedef enum logic [1:0] {
        GHS_ACP_READY,
        GHS_ACP_BUSY,
        GHS_ACP_WAIT
    } ghs_acp_type;

    // Whole state of the interface block.
    typedef struct packed {
        ghs_src_type src;
        ghs_acp_type acp;
        logic        talk;
        logic        listen;
        logic        remote;
        logic        lockout;
        logic        srq;
        logic [7:0]  dio;
        logic        dio_oe;
        logic        dav;
        logic        eoi;
        logic        nrfd;
        logic        ndac;
        logic        tx_ready;
        logic [7:0]  rx_data;
        logic        rx_eoi;
        logic        rx_valid;
        logic [7:0]  cmd;
        logic        cmd_valid;
        logic        dev_clear;
    } ghs_state_type;

endpackage

// *** hw/ghs_iface.sv ***
// Talker, listener and byte handshake logic for the instrument bus port.
`timescale 1ns/1ps

module ghs_iface
    import ghs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [4:0] my_addr,
    input  wire logic [7:0] dio_n_in,
    output logic      [7:0] dio_n_out,
    output logic      [7:0] dio_n_oe,
    input  wire logic       dav_n_in,
    output logic            dav_n_out,
    output logic            dav_n_oe,
    input  wire logic       nrfd_n_in,
    output logic            nrfd_n_out,
    output logic            nrfd_n_oe,
    input  wire logic       ndac_n_in,
    output logic            ndac_n_out,
    output logic            ndac_n_oe,
    input  wire logic       atn_n,
    input  wire logic       ren_n,
    input  wire logic       ifc_n,
    input  wire logic       eoi_n_in,
    output logic            eoi_n_out,
    output logic            eoi_n_oe,
    output logic            srq_n_out,
    output logic            srq_n_oe,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic      [7:0] rx_data,
    output logic            rx_eoi,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic      [7:0] cmd_byte,
    output logic            cmd_valid,
    output logic            talk_active,
    output logic            listen_active,
    output logic            remote,
    output logic            lockout,
    output logic            dev_clear,
    input  wire logic       service_req,
    input  wire logic       service_clr
);

    ghs_state_type st;
    ghs_state_type next_st;

    // -------------------------------------------------------------------
    // Bus lines decoded to positive truth.
    // -------------------------------------------------------------------
    logic       atn;
    logic       dav_seen;
    logic       nrfd_rel;
    logic       ndac_rel;
    logic [7:0] bus_byte;
    logic       ifc;
    logic       attn_byte;

    // Low level means asserted on every line; invert ATN, DAV, DIO and IFC here, but keep NRFD and NDAC as released flags.
    assign atn      = ~atn_n;
    assign dav_seen = ~dav_n_in;
    assign nrfd_rel = nrfd_n_in;
    assign ndac_rel = ndac_n_in;
    assign bus_byte = ~dio_n_in;
    assign ifc      = ~ifc_n;
    assign attn_byte = (st.acp == GHS_ACP_READY) && dav_seen && atn;

    // -------------------------------------------------------------------
    // Next-state logic.
    // -------------------------------------------------------------------
    // Addressing is decoded from the same captured byte that the acceptor
    // handshake takes, so a command is seen exactly once per handshake.
    always_comb begin
        logic [1:0] grp;
        logic [4:0] adr;
        grp = bus_byte[6:5];
        adr = bus_byte[4:0];
        next_st = st;
        next_st.cmd_valid = 1'b0;
        next_st.dev_clear = 1'b0;
        next_st.remote = ~ren_n;
        if (ren_n) begin
            next_st.lockout = 1'b0;
        end
        // Service request: set wins over clear.
        if (service_req) begin
            next_st.srq = 1'b1;
        end else if (service_clr) begin
            next_st.srq = 1'b0;
        end

        // Acceptor side, also active under ATN for addressing.
        unique case (st.acp)
            GHS_ACP_READY: begin
                // NRFD held low only while a listener still holds an unread byte outside ATN.
                next_st.nrfd = ~(st.listen & st.rx_valid) | atn;
                next_st.ndac = 1'b0;
                // An active talker sees its own DAV on the bus; pulling
                // NRFD or NDAC here would stall its own source forever.
                if (st.talk && !atn) begin
                    next_st.nrfd = 1'b1;
                    next_st.ndac = 1'b1;
                end
                if (dav_seen && (atn || (st.listen && !st.rx_valid))) begin
                    next_st.nrfd = 1'b0;
                    next_st.acp  = GHS_ACP_BUSY;
                    if (atn) begin
                        next_st.cmd       = bus_byte;
                        next_st.cmd_valid = 1'b1;
                    end else begin
                        next_st.rx_data  = bus_byte;
                        next_st.rx_eoi   = ~eoi_n_in;
                        next_st.rx_valid = 1'b1;
                    end
                end
            end
            GHS_ACP_BUSY: begin
                next_st.ndac = 1'b1;
                next_st.acp  = GHS_ACP_WAIT;
            end
            GHS_ACP_WAIT: begin
                if (!dav_seen) begin
                    next_st.ndac = 1'b0;
                    next_st.acp  = GHS_ACP_READY;
                end
            end
            default: next_st.acp = GHS_ACP_READY;
        endcase
        if (st.rx_valid && rx_ready) begin
            next_st.rx_valid = 1'b0;
        end

        // Address and command decode on a byte taken under ATN.
        if (attn_byte) begin
            if (grp == GHS_GROUP_TALK) begin
                if (adr == my_addr) begin
                    next_st.talk   = 1'b1;
                    next_st.listen = 1'b0;
                end else begin
                    next_st.talk = 1'b0;
                end
            end else if (grp == GHS_GROUP_LISTEN) begin
                if (adr == GHS_ADDR_UNCMD) begin
                    next_st.listen = 1'b0;
                end else if (adr == my_addr) begin
                    next_st.listen = 1'b1;
                    next_st.talk   = 1'b0;
                end
            end else if (grp == GHS_GROUP_UNIV) begin
                if (bus_byte[6:0] == GHS_CMD_DCL) begin
                    next_st.dev_clear = 1'b1;
                    next_st.srq       = service_req;
                end else if (bus_byte[6:0] == GHS_CMD_LLO) begin
                    next_st.lockout = ~ren_n;
                end
            end
        end

        // Source side runs alone while addressed and ATN is false.
        next_st.tx_ready = 1'b0;
        unique case (st.src)
            GHS_SRC_IDLE: begin
                next_st.dav    = 1'b0;
                next_st.dio_oe = 1'b0;
                next_st.eoi    = 1'b0;
                if (st.talk && !atn && tx_valid) begin
                    next_st.dio      = tx_data;
                    next_st.eoi      = tx_last;
                    next_st.dio_oe   = 1'b1;
                    next_st.tx_ready = 1'b1;
                    next_st.src      = GHS_SRC_SETUP;
                end
            end
            GHS_SRC_SETUP: begin
                if (nrfd_rel && !atn) begin
                    next_st.dav = 1'b1;
                    next_st.src = GHS_SRC_VALID;
                end
            end
            GHS_SRC_VALID: begin
                if (ndac_rel) begin
                    next_st.dav = 1'b0;
                    next_st.src = GHS_SRC_DONE;
                end
            end
            GHS_SRC_DONE: begin
                next_st.dio_oe = 1'b0;
                next_st.eoi    = 1'b0;
                next_st.src    = GHS_SRC_IDLE;
            end
            default: next_st.src = GHS_SRC_IDLE;
        endcase
        // Talker stays usable in local and remote alike: no mode gates it.

        // Interface clear drops both addressed states at once.
        if (ifc) begin
            next_st.talk   = 1'b0;
            next_st.listen = 1'b0;
            next_st.src    = GHS_SRC_IDLE;
            next_st.dav    = 1'b0;
            next_st.dio_oe = 1'b0;
            next_st.eoi    = 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // State register.
    // -------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st          <= '0;
            st.src      <= GHS_SRC_IDLE;
            st.acp      <= GHS_ACP_READY;
            // NRFD and NDAC are kept as released flags, so a one here
            // leaves both lines at their false, high level.
            st.nrfd     <= 1'b1;
            st.ndac     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come from the state register, data, DAV and EOI inverted to the bus; NRFD, NDAC and SRQ drive a fixed low through their enables.
    assign dio_n_out     = ~st.dio;
    assign dio_n_oe      = {8{st.dio_oe}};
    assign dav_n_out     = ~st.dav;
    assign dav_n_oe      = st.dio_oe;
    assign eoi_n_out     = ~st.eoi;
    assign eoi_n_oe      = st.dio_oe;
    assign nrfd_n_out    = 1'b0;
    assign nrfd_n_oe     = ~st.nrfd;
    assign ndac_n_out    = 1'b0;
    assign ndac_n_oe     = ~st.ndac;
    assign srq_n_out     = 1'b0;
    assign srq_n_oe      = st.srq;
    assign tx_ready      = st.tx_ready;
    assign rx_data       = st.rx_data;
    assign rx_eoi        = st.rx_eoi;
    assign rx_valid      = st.rx_valid;
    assign cmd_byte      = st.cmd;
    assign cmd_valid     = st.cmd_valid;
    assign talk_active   = st.talk;
    assign listen_active = st.listen;
    assign remote        = st.remote;
    assign lockout       = st.lockout;
    assign dev_clear     = st.dev_clear;

    // -------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------
    a_dav_after_nrfd: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st.dav) |-> $past(nrfd_rel)) else $error("DAV without NRFD.");
    a_data_before_dav: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st.dav) |-> $past(st.dio_oe)) else $error("DAV before data.");
    a_dav_release: assert property (@(posedge clk) disable iff (sys_rst)
        (st.src == GHS_SRC_VALID && ndac_rel) |=> !st.dav)
        else $error("DAV not released.");
    a_nrfd_on_take: assert property (@(posedge clk) disable iff (sys_rst)
        (st.acp == GHS_ACP_BUSY) |-> !st.nrfd) else $error("NRFD high.");
    a_ndac_release: assert property (@(posedge clk) disable iff (sys_rst)
        (st.acp == GHS_ACP_BUSY) |=> st.ndac) else $error("NDAC held.");
    a_ndac_relow: assert property (@(posedge clk) disable iff (sys_rst)
        (st.acp == GHS_ACP_WAIT && !dav_seen) |=> !st.ndac)
        else $error("NDAC not low.");
    a_talk_no_atn: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st.dio_oe) |-> $past(st.talk && !atn)) else $error("Bad talk.");
    a_ifc_clears: assert property (@(posedge clk) disable iff (sys_rst)
        ifc |=> !st.talk && !st.listen) else $error("IFC ignored.");
    a_not_both: assert property (@(posedge clk) disable iff (sys_rst)
        !(st.talk && st.listen)) else $error("Talk and listen.");
    a_srq_set: assert property (@(posedge clk) disable iff (sys_rst)
        service_req && !attn_byte |=> st.srq) else $error("SRQ lost.");
    a_remote_ren: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> st.remote == $past(~ren_n)) else $error("REN ignored.");
    // A talker must leave both acceptor lines free for the far listeners.
    a_talker_frees_hs: assert property (@(posedge clk) disable iff (sys_rst)
        (st.talk && !atn && st.acp == GHS_ACP_READY) |=> st.nrfd && st.ndac)
        else $error("Talker holds handshake.");
    // A held byte must neither vanish nor be overwritten before it is read.
    a_rx_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (st.rx_valid && !rx_ready) |=> st.rx_valid && $stable(st.rx_data))
        else $error("Held byte lost.");

endmodule // ghs_iface

// *** dv/ghs_bus_model.sv ***
// Model of the controller and of a remote instrument on the bus.
`timescale 1ns/1ps

module ghs_bus_model (
    input  wire logic       clk,
    input  wire logic [7:0] dio_n_in,
    input  wire logic       dav_n_in,
    input  wire logic       nrfd_n_in,
    input  wire logic       ndac_n_in,
    input  wire logic       eoi_n_in,
    output logic      [7:0] p_dio_n,
    output logic            p_dav_n,
    output logic            p_eoi_n,
    output logic            p_nrfd_n,
    output logic            p_ndac_n,
    output logic            atn_n
);
    // ------------------------------------------------------------
    // Open-collector drivers; a released line rests on its pull-up.
    // ------------------------------------------------------------
    initial begin
        {p_dio_n, p_dav_n, p_eoi_n} = 10'h3FF;
        {p_nrfd_n, p_ndac_n, atn_n} = 3'h7;
    end

    // Bounded wait on a line: sel 0 is NRFD, 1 is NDAC, 2 is DAV.
    task automatic wait_lvl(input int sel, input logic v, input int lim,
                            output bit ok);
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(posedge clk);
            ok = ((sel == 0) ? nrfd_n_in : (sel == 1) ? ndac_n_in
                                                      : dav_n_in) === v;
        end
    endtask

    // Source one byte; a refused byte gives up after lim cycles.
    task automatic send(input logic [7:0] b, input bit atn, input bit eoi,
                        input int lim, output bit ok);
        @(posedge clk);
        atn_n <= ~atn;
        {p_nrfd_n, p_ndac_n} <= 2'h3;
        p_dio_n <= ~b;
        p_eoi_n <= ~eoi;
        wait_lvl(0, 1'b1, lim, ok);
        if (ok) begin
            p_dav_n <= 1'b0;
            wait_lvl(1, 1'b1, lim, ok);
        end
        p_dav_n <= 1'b1;
        @(posedge clk);
        {p_dio_n, p_eoi_n} <= 9'h1FF;
        atn_n <= 1'b1;
    endtask

    // Accept one byte; NRFD is held low for hold cycles to stall.
    task automatic recv(input int hold, output logic [7:0] b,
                        output logic e, output bit ok, output bit bad);
        bad = 1'b0;
        @(posedge clk);
        {p_nrfd_n, p_ndac_n} <= 2'h0;
        repeat (hold) begin
            @(posedge clk);
            if (dav_n_in !== 1'b1) bad = 1'b1;
        end
        p_nrfd_n <= 1'b1;
        wait_lvl(2, 1'b0, 200, ok);
        b = ~dio_n_in;
        e = ~eoi_n_in;
        p_nrfd_n <= 1'b0;
        repeat (hold) @(posedge clk);
        p_ndac_n <= 1'b1;
        if (ok) wait_lvl(2, 1'b1, 200, ok);
        p_ndac_n <= 1'b0;
    endtask
endmodule // ghs_bus_model

// *** dv/tb_top.sv ***
// Self-checking bench for the instrument bus port.
`timescale 1ns/1ps

module tb_top;
    import ghs_pkg::*;

    // ------------------------------------------------------------
    // Stimulus, observed outputs and the resolved bus lines.
    // ------------------------------------------------------------
    localparam logic [7:0] la = {1'b0, GHS_GROUP_LISTEN, GHS_DEF_ADDR};
    localparam logic [7:0] ta = {1'b0, GHS_GROUP_TALK, GHS_DEF_ADDR};
    logic       clk = 1'b0, sys_rst = 1'b1, ren_n = 1'b1, ifc_n = 1'b1;
    logic       tx_last = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic       service_req = 1'b0, service_clr = 1'b0;
    logic [4:0] my_addr = GHS_DEF_ADDR;
    logic [7:0] tx_data = 8'h00, dio_n_out, dio_n_oe, p_dio_n, rx_data;
    logic [7:0] cmd_byte, last_cmd;
    logic       dav_n_out, dav_n_oe, nrfd_n_out, nrfd_n_oe, ndac_n_out;
    logic       ndac_n_oe, eoi_n_out, eoi_n_oe, srq_n_out, srq_n_oe;
    logic       p_dav_n, p_eoi_n, p_nrfd_n, p_ndac_n, atn_n, tx_ready;
    logic       rx_eoi, rx_valid, cmd_valid, talk_active, listen_active;
    logic       remote, lockout, dev_clear;
    int         n_mismatch = 0, cmp_count = 0, n_dcl = 0;
    wire  [7:0] dio_n_in = (dio_n_out | ~dio_n_oe) & p_dio_n;
    wire        dav_n_in = (dav_n_out | ~dav_n_oe) & p_dav_n;
    wire        nrfd_n_in = (nrfd_n_out | ~nrfd_n_oe) & p_nrfd_n;
    wire        ndac_n_in = (ndac_n_out | ~ndac_n_oe) & p_ndac_n;
    wire        eoi_n_in = (eoi_n_out | ~eoi_n_oe) & p_eoi_n;

    ghs_iface ghs_iface_inst (
        .clk, .sys_rst, .my_addr, .dio_n_in, .dio_n_out, .dio_n_oe,
        .dav_n_in, .dav_n_out, .dav_n_oe, .nrfd_n_in, .nrfd_n_out,
        .nrfd_n_oe, .ndac_n_in, .ndac_n_out, .ndac_n_oe, .atn_n, .ren_n,
        .ifc_n, .eoi_n_in, .eoi_n_out, .eoi_n_oe, .srq_n_out, .srq_n_oe,
        .tx_data, .tx_last, .tx_valid, .tx_ready, .rx_data, .rx_eoi,
        .rx_valid, .rx_ready, .cmd_byte, .cmd_valid, .talk_active,
        .listen_active, .remote, .lockout, .dev_clear, .service_req,
        .service_clr);
    ghs_bus_model ghs_bus_model_inst (
        .clk, .dio_n_in, .dav_n_in, .nrfd_n_in, .ndac_n_in, .eoi_n_in,
        .p_dio_n, .p_dav_n, .p_eoi_n, .p_nrfd_n, .p_ndac_n, .atn_n);

    // Clock of 125 MHz.
    always #4 clk = ~clk;

    // Pulses stand one cycle, so they are caught here as they happen.
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) last_cmd <= cmd_byte;
        if (dev_clear === 1'b1) n_dcl <= n_dcl + 1;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A handshake that ran out of time ends the run at once.
    task automatic need(input bit ok);
        chk(ok, 1'b1);
        if (!ok) test_done;
    endtask

    // One byte under ATN, then the command byte and, unless tl is 3, the addressed flags are compared.
    task automatic cmd(input logic [7:0] b, input logic [1:0] tl);
        bit ok;
        ghs_bus_model_inst.send(b, 1'b1, 1'b0, 100, ok);
        need(ok);
        repeat (2) @(posedge clk);
        chk(last_cmd, b);
        if (tl != 2'h3) chk({talk_active, listen_active}, tl);
    endtask

    // The buffer is emptied first and left full afterwards, so a byte
    // that follows meets a busy listener.
    task automatic take_rx(input logic [7:0] b, input bit eoi);
        bit ok;
        @(posedge clk) rx_ready <= 1'b1;
        @(posedge clk) rx_ready <= 1'b0;
        ghs_bus_model_inst.send(b, 1'b0, eoi, 100, ok);
        need(ok);
        chk({rx_valid, rx_eoi, 6'h00}, {1'b1, eoi, 6'h00});
        chk(rx_data, b);
    endtask

    // The far side stalls NRFD three cycles before each byte.
    task automatic talk_byte(input logic [7:0] b, input logic last);
        logic [7:0] rb;
        logic       re;
        bit         ok, bad, got;
        got = 1'b0;
        fork
            ghs_bus_model_inst.recv(3, rb, re, ok, bad);
            begin
                @(posedge clk);
                {tx_data, tx_last, tx_valid} <= {b, last, 1'b1};
                for (int i = 0; i < 50 && !got; i++) begin
                    @(posedge clk);
                    got = tx_ready === 1'b1;
                end
                tx_valid <= 1'b0;
            end
        join
        need(got && ok);
        chk(bad, 1'b0);
        chk(rb, b);
        chk(re, last);
    endtask

    task automatic s_bus;
        bit ok;
        cmd(la, 2'h1);
        take_rx(8'hA5, 1'b1);
        ghs_bus_model_inst.send(8'h5A, 1'b0, 1'b0, 30, ok);
        chk(ok, 1'b0);
        take_rx(8'h3C, 1'b0);
        cmd(ta, 2'h2);
        @(posedge clk) ren_n <= 1'b0;
        talk_byte(8'h41, 1'b0);
        chk(remote, 1'b1);
        @(posedge clk) ren_n <= 1'b1;
        talk_byte(8'h0D, 1'b1);
        chk(remote, 1'b0);
        cmd(la, 2'h1);
        cmd(ta, 2'h2);
        cmd(ta ^ 8'h01, 2'h0);
        cmd(ta, 2'h2);
        cmd({1'b0, GHS_GROUP_TALK, GHS_ADDR_UNCMD}, 2'h0);
        cmd(la, 2'h1);
        cmd({1'b0, GHS_GROUP_LISTEN, GHS_ADDR_UNCMD}, 2'h0);
        ghs_bus_model_inst.send(8'h22, 1'b0, 1'b0, 30, ok);
        chk(ok, 1'b0);
        for (int k = 0; k < 2; k++) begin
            cmd(k ? ta : la, 2'h3);
            @(posedge clk) ifc_n <= 1'b0;
            repeat (2) @(posedge clk);
            ifc_n <= 1'b1;
            repeat (2) @(posedge clk);
            chk({talk_active, listen_active}, 8'h00);
        end
    endtask

    // Service request set, cleared locally, then cleared by a command.
    task automatic s_srq;
        int d0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) {service_req, service_clr} <= {1'b1, k == 2};
            @(posedge clk) {service_req, service_clr} <= {1'b0, k == 0};
            repeat (2) @(posedge clk);
            chk({srq_n_oe, srq_n_out}, k ? 2'h2 : 2'h0);
        end
        d0 = n_dcl;
        cmd({1'b0, GHS_CMD_DCL}, 2'h3);
        chk(8'(n_dcl - d0), 8'h01);
        chk(srq_n_oe, 1'b0);
        @(posedge clk) ren_n <= 1'b0;
        cmd({1'b0, GHS_CMD_LLO}, 2'h3);
        chk({remote, lockout}, 2'h3);
    endtask

    // Reset for four cycles, then run the scenarios in turn.
    initial begin
        repeat (4) @(posedge clk);
        chk(dio_n_oe, 8'h00);
        chk({dav_n_oe, eoi_n_oe, srq_n_oe, talk_active}, 8'h00);
        chk({nrfd_n_oe, listen_active}, 8'h00);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        s_bus;
        s_srq;
        test_done;
    end

    // Watchdog in case the whole run stalls.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done;
    end
endmodule // tb_top
